// ==== hdl/ssp_pkg.sv ====
// constants and types for the byte-wide serial port
// assumes a single core clock domain
package ssp_pkg;
  localparam logic [7:0] ADDR_DATA = 8'h7f;
  localparam logic [7:0] ADDR_CTRL = 8'hf8;
  localparam logic [7:0] CTRL_RST = 8'h05;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam int BIT_RATE_LO = 0;
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] LAST_EDGE = 4'hf;
  localparam logic [3:0] SAMPLES = 4'h8;
  localparam logic [3:0] HALF_BASE = 4'h1;
  localparam logic [4:0] BURST_EDGES = 5'h10;

  typedef struct packed {
    logic done;
    logic write_collision_flag;
    logic en;
    logic role;
    logic cpol;
    logic cpha;
    logic [1:0] rate;
  } ssp_ctrl_t;

  typedef struct packed {
    logic o;
    logic oe;
  } ssp_pin_t;

  typedef enum {ST_IDLE, ST_RUN} ssp_state_t;
endpackage

// ==== hdl/ssp_port.sv ====
// serial port, master or slave, with control and data registers
// assumes pins and register strobes synchronous to CLK
// Contract
// - miso input as master, output as slave
// - eight bits per byte, msb first
// - mosi output as master, input as slave
// - slave shifts only while select low
// - slave reads select level in rate bit
// - done flag bit 7 set each byte
// - collision flag bit 6 on busy write
// - role bit 4 selects master or slave
// - polarity bit 3 sets clock idle level
// - phase bit 2 picks change edge
// - rate field divides core clock 2..16
// - interrupt shares vector, flags inspected
// - master write starts eight-clock burst
// - select pin ignored in master mode
// - master shifts, then latches data, flags
// - slave write loads byte, external clock
// - slave updates data only after byte
// - slave ends on 8th clock or select
// - polarity and phase match both ends
`timescale 1ns/1ps
`default_nettype none
module ssp_port #(
  parameter int DEPTH = 2,
  parameter int WIDTH = 8
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_WE,
  input wire logic SFR_RE,
  output logic [7:0] SFR_RDATA,
  input wire logic SERIAL_CLOCK_I,
  output var ssp_pkg::ssp_pin_t SERIAL_CLOCK_PIN,
  input wire logic MOSI_I,
  output var ssp_pkg::ssp_pin_t MOSI_PIN,
  input wire logic MISO_I,
  output var ssp_pkg::ssp_pin_t MISO_PIN,
  input wire logic SEL_N_I,
  output var ssp_pkg::ssp_pin_t SEL_N_PIN,
  input wire logic [3:0] GPIO_OUT,
  input wire logic [3:0] GPIO_OE,
  output logic [3:0] GPIO_IN,
  output logic XFER_IRQ,
  output logic RX_VALID,
  input wire logic RX_READY,
  output logic [WIDTH-1:0] RX_DATA
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (WIDTH != ssp_pkg::BYTE_BITS || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
      $error("ssp_port: WIDTH must be 8, DEPTH a power of two >= 2");
    end
  endgenerate

  ssp_pkg::ssp_ctrl_t ctrl_reg;
  ssp_pkg::ssp_state_t state_reg;
  logic [7:0] data_reg;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic [3:0] half_reg;
  logic [3:0] edge_reg;
  logic [3:0] samp_reg;
  logic sclk_reg;
  logic prev_sclk_reg;
  logic pend_reg;
  logic end_reg;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_reg;
  logic [AW:0] rp_reg;

  logic wr_data, wr_ctrl, rd_data;
  logic is_master, is_slave, s_act;
  logic [3:0] half_len;
  logic m_tick, s_edge, edge_ev, lead, samp, shft, din;
  logic busy, m_go, end_req, full, empty, push, pop;

  assign wr_data = SFR_WE && SFR_ADDR == ssp_pkg::ADDR_DATA;
  assign wr_ctrl = SFR_WE && SFR_ADDR == ssp_pkg::ADDR_CTRL;
  assign rd_data = SFR_RE && SFR_ADDR == ssp_pkg::ADDR_DATA;
  assign is_master = ctrl_reg.en & ctrl_reg.role;
  assign is_slave = ctrl_reg.en & ~ctrl_reg.role;
  assign s_act = is_slave & ~SEL_N_I;
  assign half_len = 4'(ssp_pkg::HALF_BASE << ctrl_reg.rate);
  assign m_tick = state_reg == ssp_pkg::ST_RUN && half_reg == half_len - 4'h1;
  assign s_edge = s_act & (SERIAL_CLOCK_I != prev_sclk_reg);
  assign edge_ev = m_tick | s_edge;
  // leading edge leaves the idle level
  assign lead = is_master ? ~edge_reg[0] : (SERIAL_CLOCK_I != ctrl_reg.cpol);
  assign samp = edge_ev & (lead ^ ctrl_reg.cpha);
  // phase 1: first leading edge only presents the msb
  assign shft = edge_ev & ~(lead ^ ctrl_reg.cpha) & ~(ctrl_reg.cpha & lead & samp_reg == 4'h0);
  assign din = is_master ? MISO_I : MOSI_I;
  assign busy = state_reg == ssp_pkg::ST_RUN || pend_reg || (is_slave && samp_reg != 4'h0);
  assign m_go = is_master & pend_reg & state_reg == ssp_pkg::ST_IDLE & ~full;
  assign end_req = (m_tick && edge_reg == ssp_pkg::LAST_EDGE)
                 | (is_slave && ctrl_reg.cpha && samp && samp_reg == ssp_pkg::SAMPLES - 4'h1)
                 | (is_slave && !ctrl_reg.cpha && SEL_N_I && samp_reg == ssp_pkg::SAMPLES);
  // control register
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ctrl_reg <= ssp_pkg::CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= SFR_WDATA;
      end
      if (end_reg) begin
        ctrl_reg.done <= 1'b1;
      end else if (wr_ctrl) begin
        ctrl_reg.done <= SFR_WDATA[7];
      end else if (rd_data) begin
        ctrl_reg.done <= 1'b0;
      end
      if (wr_data && busy) begin
        ctrl_reg.write_collision_flag <= 1'b1;
      end
    end
  end
  // data register: cpu write or completed byte
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      data_reg <= ssp_pkg::DATA_RST;
    end else if (wr_data && !busy) begin
      data_reg <= SFR_WDATA;
    end else if (end_reg) begin
      data_reg <= rx_reg;
    end
  end
  // register read port
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      SFR_RDATA <= 8'h00;
    end else if (SFR_RE) begin
      case (SFR_ADDR)
        ssp_pkg::ADDR_DATA: SFR_RDATA <= data_reg;
        ssp_pkg::ADDR_CTRL: begin
          SFR_RDATA <= ctrl_reg;
          if (is_slave) begin
            SFR_RDATA[ssp_pkg::BIT_RATE_LO] <= SEL_N_I;
          end
        end
        default: SFR_RDATA <= 8'h00;
      endcase
    end
  end
  // shift registers, msb first
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
    end else begin
      if (wr_data && !busy) begin
        tx_reg <= SFR_WDATA;
      end else if (shft) begin
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
      if (samp) begin
        rx_reg <= {rx_reg[6:0], din};
      end
    end
  end
  // bits sampled in the current byte
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      samp_reg <= 4'h0;
    end else if (!ctrl_reg.en || m_go || end_req) begin
      samp_reg <= 4'h0;
    end else if (is_slave && SEL_N_I) begin
      samp_reg <= 4'h0;
    end else if (samp && samp_reg < ssp_pkg::SAMPLES) begin
      samp_reg <= samp_reg + 4'h1;
    end
  end
  // master sequencer
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_reg <= ssp_pkg::ST_IDLE;
      pend_reg <= 1'b0;
    end else begin
      case (state_reg)
        ssp_pkg::ST_IDLE: begin
          if (m_go) begin
            state_reg <= ssp_pkg::ST_RUN;
          end
        end
        ssp_pkg::ST_RUN: begin
          if (!is_master || (m_tick && edge_reg == ssp_pkg::LAST_EDGE)) begin
            state_reg <= ssp_pkg::ST_IDLE;
          end
        end
        default: state_reg <= ssp_pkg::ST_IDLE;
      endcase
      if (!is_master || m_go) begin
        pend_reg <= 1'b0;
      end else if (wr_data && !busy) begin
        pend_reg <= 1'b1;
      end
    end
  end
  // bit-rate divider and clock edges
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      half_reg <= 4'h0;
      edge_reg <= 4'h0;
      sclk_reg <= 1'b0;
    end else begin
      if (state_reg != ssp_pkg::ST_RUN || m_tick) begin
        half_reg <= 4'h0;
      end else begin
        half_reg <= half_reg + 4'h1;
      end
      if (m_go) begin
        edge_reg <= 4'h0;
      end else if (m_tick) begin
        edge_reg <= edge_reg + 4'h1;
      end
      if (state_reg != ssp_pkg::ST_RUN) begin
        sclk_reg <= ctrl_reg.cpol;
      end else if (m_tick) begin
        sclk_reg <= ~sclk_reg;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      prev_sclk_reg <= 1'b0;
      end_reg <= 1'b0;
    end else begin
      prev_sclk_reg <= SERIAL_CLOCK_I;
      end_reg <= end_req;
    end
  end
  // received-byte buffer; a full buffer holds back the next master start
  assign full = (wp_reg ^ rp_reg) == {1'b1, {AW{1'b0}}};
  assign empty = wp_reg == rp_reg;
  assign push = end_reg & ~full;
  assign pop = RX_READY & ~empty;
  assign RX_VALID = ~empty;
  assign RX_DATA = mem[rp_reg[AW-1:0]];

  always_ff @(posedge CLK) begin
    if (push) begin
      mem[wp_reg[AW-1:0]] <= rx_reg;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      if (push) begin
        wp_reg <= wp_reg + {{AW{1'b0}}, 1'b1};
      end
      if (pop) begin
        rp_reg <= rp_reg + {{AW{1'b0}}, 1'b1};
      end
    end
  end
  // pin sharing with the general-purpose port
  always_comb begin
    if (ctrl_reg.en) begin
      SERIAL_CLOCK_PIN = '{o: sclk_reg, oe: is_master};
      MOSI_PIN = '{o: tx_reg[7], oe: is_master};
      MISO_PIN = '{o: tx_reg[7], oe: is_slave};
      SEL_N_PIN = '{o: 1'b0, oe: 1'b0};
    end else begin
      SERIAL_CLOCK_PIN = '{o: GPIO_OUT[0], oe: GPIO_OE[0]};
      MOSI_PIN = '{o: GPIO_OUT[1], oe: GPIO_OE[1]};
      MISO_PIN = '{o: GPIO_OUT[2], oe: GPIO_OE[2]};
      SEL_N_PIN = '{o: GPIO_OUT[3], oe: GPIO_OE[3]};
    end
  end
  assign GPIO_IN = {SEL_N_I, MISO_I, MOSI_I, SERIAL_CLOCK_I};
  assign XFER_IRQ = ctrl_reg.done;
  // checking helpers
  logic sclk_d_reg;
  logic [4:0] stab_reg;
  logic [4:0] tog_reg;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      sclk_d_reg <= 1'b0;
      stab_reg <= 5'h00;
      tog_reg <= 5'h00;
    end else begin
      sclk_d_reg <= sclk_reg;
      stab_reg <= m_go ? 5'h00 : (sclk_reg != sclk_d_reg) ? 5'h01 : stab_reg + 5'h01;
      tog_reg <= m_go ? 5'h00 : (sclk_reg != sclk_d_reg) ? tog_reg + 5'h01 : tog_reg;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_finish;
    m_tick && edge_reg == ssp_pkg::LAST_EDGE;
  endsequence
  sequence s_busy_write;
    wr_data && busy;
  endsequence

  chk_miso_dir: assert property (ctrl_reg.en |-> MISO_PIN.oe == is_slave)
    else $error("miso direction wrong");
  chk_mosi_dir: assert property (ctrl_reg.en |-> MOSI_PIN.oe == is_master)
    else $error("mosi direction wrong");
  chk_sclk_idle: assert property (is_master && state_reg == ssp_pkg::ST_IDLE && $stable(ctrl_reg.cpol)
      |-> SERIAL_CLOCK_PIN.o == ctrl_reg.cpol)
    else $error("clock idle level wrong");
  chk_burst_len: assert property (s_finish |=> ##1 tog_reg == ssp_pkg::BURST_EDGES)
    else $error("burst not sixteen edges");
  chk_rate_half: assert property (state_reg == ssp_pkg::ST_RUN && sclk_reg != sclk_d_reg
      |-> stab_reg == {1'b0, half_len})
    else $error("clock half period wrong");
  chk_done_set: assert property (s_finish |=> ##1 ctrl_reg.done && XFER_IRQ)
    else $error("done flag not set");
  chk_write_collision_flag_set: assert property (s_busy_write |=> ctrl_reg.write_collision_flag)
    else $error("collision not flagged");
  chk_sel_gate: assert property (is_slave && SEL_N_I |=> samp_reg == 4'h0)
    else $error("slave shifted while deselected");
  chk_data_hold: assert property (!$stable(data_reg) |-> $past(end_reg || wr_data))
    else $error("data register changed mid byte");
  chk_sel_read: assert property (SFR_RE && SFR_ADDR == ssp_pkg::ADDR_CTRL && is_slave
      |=> SFR_RDATA[0] == $past(SEL_N_I))
    else $error("select level not readable");
  chk_gpio_pins: assert property (!ctrl_reg.en |-> SERIAL_CLOCK_PIN.o == GPIO_OUT[0]
      && MISO_PIN.oe == GPIO_OE[2])
    else $error("pins not returned to port");
endmodule
`default_nettype wire

// ==== test/ssp_far_end.sv ====
// behavioural far end of the serial link, slave or master
// assumes the bench resolves the shared lines and picks din
`timescale 1ns/1ps
`default_nettype none
module ssp_far_end (
  input wire logic clk,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  output logic sclk_o,
  output logic sel_n_o,
  output logic [7:0] rx
);
  logic [7:0] sh;
  initial begin
    dout = 1'b1;
    sclk_o = 1'b0;
    sel_n_o = 1'b1;
    rx = 8'h00;
    sh = 8'h00;
  end
  task automatic load(input logic [7:0] b);
    sh = cpha ? b : {b[6:0], 1'b0};
    dout = cpha ? ~b[7] : b[7];
  endtask
  // change on one clock edge, sample on the other
  always @(sclk) begin
    if ((sclk != cpol) == cpha) begin
      dout = sh[7];
      sh = {sh[6:0], 1'b0};
    end else begin
      rx = {rx[6:0], din};
    end
  end
  task automatic run(input logic [7:0] b, input logic sel, input int half, input logic keep);
    sclk_o <= cpol;
    @(posedge clk);
    load(b);
    sel_n_o <= ~sel;
    repeat (2 * half) @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      repeat (half) @(posedge clk);
      sclk_o <= ~sclk_o;
    end
    repeat (2 * half) @(posedge clk);
    // phase 1 may leave the select low into the next byte
    if (!keep) begin
      sel_n_o <= 1'b1;
      dout = ~dout;
    end
  endtask
endmodule
`default_nettype wire

// ==== test/spi_master_slave_port_tb_top.sv ====
// bench for the serial port: registers, pins, master and slave bytes
// assumes the far end model and the design package compile first
`timescale 1ns/1ps
`default_nettype none
module spi_master_slave_port_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wd = 8'h00;
  logic we = 1'b0;
  logic re = 1'b0;
  logic rdy = 1'b0;
  logic [3:0] g_out = 4'h6;
  logic [3:0] g_oe = 4'hf;
  logic [7:0] rdata;
  logic [7:0] rxd;
  logic [3:0] g_in;
  logic irq;
  logic rxv;
  ssp_pkg::ssp_pin_t sck_p;
  ssp_pkg::ssp_pin_t mosi_p;
  ssp_pkg::ssp_pin_t miso_p;
  ssp_pkg::ssp_pin_t sel_p;
  logic f_mst = 1'b0;
  logic f_cpol = 1'b0;
  logic f_cpha = 1'b0;
  logic f_dout;
  logic f_sck;
  logic f_sel;
  logic [7:0] f_rx;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int tog = 0;
  int t0 = 0;
  int t1 = 0;
  logic sq = 1'b0;
  logic [7:0] ctl;
  logic [7:0] v;
  logic [7:0] dtx [4] = '{8'h1d, 8'hc2, 8'h6b, 8'h38};
  logic [7:0] ptx [4] = '{8'h4e, 8'h91, 8'hb3, 8'h07};
  wire logic sck_w = sck_p.oe ? sck_p.o : f_sck;
  wire logic mosi_w = mosi_p.oe ? mosi_p.o : f_dout;
  wire logic miso_w = miso_p.oe ? miso_p.o : f_dout;
  wire logic sel_w = sel_p.oe ? sel_p.o : f_sel;
  wire logic f_din = f_mst ? miso_w : mosi_w;
  always #4 clk = ~clk;
  ssp_port #(.DEPTH(2), .WIDTH(8)) uut (
    .CLK(clk), .SYS_RST(rst), .SFR_ADDR(addr), .SFR_WDATA(wd), .SFR_WE(we), .SFR_RE(re),
    .SFR_RDATA(rdata), .SERIAL_CLOCK_I(sck_w), .SERIAL_CLOCK_PIN(sck_p), .MOSI_I(mosi_w),
    .MOSI_PIN(mosi_p), .MISO_I(miso_w), .MISO_PIN(miso_p), .SEL_N_I(sel_w), .SEL_N_PIN(sel_p),
    .GPIO_OUT(g_out), .GPIO_OE(g_oe), .GPIO_IN(g_in), .XFER_IRQ(irq), .RX_VALID(rxv),
    .RX_READY(rdy), .RX_DATA(rxd)
  );
  ssp_far_end far (
    .clk(clk), .cpol(f_cpol), .cpha(f_cpha), .sclk(sck_w), .din(f_din),
    .dout(f_dout), .sclk_o(f_sck), .sel_n_o(f_sel), .rx(f_rx)
  );
  // serial clock edge counter and time stamps
  always @(posedge clk) begin
    cyc <= cyc + 1;
    sq <= sck_w;
    if (sck_w !== sq) begin
      tog <= tog + 1;
      t1 <= cyc;
      if (tog == 0) t0 <= cyc;
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 chk(n, e, rdata);
  endtask
  task automatic pop(input logic [7:0] e);
    chk("rx_valid", 8'h01, {7'h00, rxv});
    chk("rx_data", e, rxd);
    @(posedge clk);
    rdy <= 1'b1;
    @(posedge clk);
    rdy <= 1'b0;
    #1;
  endtask
  task automatic wait_irq();
    for (int i = 0; i < 800 && irq !== 1'b1; i++) @(posedge clk);
    #1 chk("irq", 8'h01, {7'h00, irq});
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    bad_count++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1 chk("pins", 8'h6f, {sel_p.o, miso_p.o, mosi_p.o, sck_p.o, sel_p.oe, miso_p.oe, mosi_p.oe, sck_p.oe});
    chk("gpio_in", 8'h06, {4'h0, g_in});
    rd(ssp_pkg::ADDR_CTRL, ssp_pkg::CTRL_RST, "ctrl_reset");
    rd(ssp_pkg::ADDR_DATA, ssp_pkg::DATA_RST, "data_reset");
    rd(8'h10, 8'h00, "unmapped");
    g_oe <= 4'h0;
    for (int m = 0; m < 4; m++) begin
      ctl = {4'h3, 2'(m), 2'(m)};
      f_cpol = ctl[3];
      f_cpha = ctl[2];
      wr(ssp_pkg::ADDR_CTRL, ctl);
      rd(ssp_pkg::ADDR_CTRL, ctl, "ctrl_master");
      far.load(ptx[m]);
      tog = 0;
      wr(ssp_pkg::ADDR_DATA, dtx[m]);
      if (m == 3) wr(ssp_pkg::ADDR_DATA, 8'hff);
      if (m == 2) begin
        repeat (60) @(posedge clk);
        #1 chk("start_held", 8'h00, 8'(tog));
        pop(ptx[0]);
        pop(ptx[1]);
      end
      wait_irq();
      chk("far_rx", dtx[m], f_rx);
      chk("toggles", 8'h10, 8'(tog));
      chk("span", 8'h0f << m, 8'(t1 - t0));
      chk("idle", {7'h00, ctl[3]}, {7'h00, sck_w});
      chk("oe_master", 8'h06, {5'h00, sck_p.oe, mosi_p.oe, miso_p.oe});
      v = ctl | 8'h80 | (m == 3 ? 8'h40 : 8'h00);
      rd(ssp_pkg::ADDR_CTRL, v, "ctrl_done");
      rd(ssp_pkg::ADDR_DATA, ptx[m], "data_master");
      rd(ssp_pkg::ADDR_CTRL, v & 8'h7f, "ctrl_after_read");
    end
    pop(ptx[2]);
    pop(ptx[3]);
    chk("rx_empty", 8'h00, {7'h00, rxv});
    f_mst = 1'b1;
    // third byte follows the second with the select still low
    for (int s = 0; s < 3; s++) begin
      ctl = s ? 8'h24 : 8'h28;
      f_cpol = ctl[3];
      f_cpha = ctl[2];
      wr(ssp_pkg::ADDR_CTRL, ctl);
      rd(ssp_pkg::ADDR_CTRL, ctl | (s < 2 ? 8'h01 : 8'h00), "ctrl_slave");
      if (s < 2) begin
        far.run(8'h00, 1'b0, 3, 1'b0);
        #1 chk("unselected", 8'h00, {7'h00, irq});
      end
      wr(ssp_pkg::ADDR_DATA, dtx[s]);
      far.run(ptx[s], 1'b1, 3, s == 1);
      wait_irq();
      chk("far_rx_slave", dtx[s], f_rx);
      chk("oe_slave", 8'h01, {5'h00, sck_p.oe, mosi_p.oe, miso_p.oe});
      rd(ssp_pkg::ADDR_DATA, ptx[s], "data_slave");
      pop(ptx[s]);
    end
    stop_test();
  end
endmodule
`default_nettype wire
